/* File: shared/fsci_defines.svh */
// Purpose: constants for the serial command interpreter of the loop controller
// Assumes: 20 MHz core clock, 4800 baud 8N1 serial link
// Notes:   rule summary below, constants only
//
// Contract
// [RQ1] question mark sends the command menu text
// [RQ2] letter A clears all latched alarms
// [RQ3] letter C zeroes the frequency sample counter
// [RQ4] letter D stops closed-loop control, enters manual state
// [RQ5] letter E leaves manual state, resumes closed-loop control
// [RQ6] F with 01..FF loads coarse/fine threshold, then parameter string
// [RQ7] H with 01..FF loads holdover threshold, then parameter string
// [RQ8] L with 01..FF loads lock limit, then parameter string
// [RQ9] M 01 voting, 02 summing averaging, then parameter string
// [RQ10] N with 01..FF loads negate threshold, then parameter string
// [RQ11] O 01 reference enable always high, 02 follows lock state
// [RQ12] letter P sends parameter string, changes nothing
// [RQ13] letter R soft-resets everything like a power cycle; code leaves the receiver, transmitter and reference edge detector running
// [RQ14] S with 0001..FFFF loads averaging cycle size, then parameter string
// [RQ15] T loads 10-bit coarse tune only in manual state, no fine bits
// [RQ16] letter V sends the version text
// [RQ17] W with 01..FF loads holdover wait, then parameter string
// [RQ18] X 01 positive, 02 negative tuning slope
// [RQ19] link is 4800 baud, 8 data bits, 1 stop, no parity
// [RQ20] timing reference is the rising edge of the 1 Hz pulse input
// [RQ21] tuning output is 14-bit, monotonic, slope selectable
// [RQ22] sender uses uppercase only; lowercase commands are ignored
// [RQ23] sender ends each command with carriage return then line feed
// [RQ24] sender never gives 00 as a two-digit argument
// [RQ25] unknown letters or bad arguments change nothing
`ifndef FSCI_DEFINES_SVH
`define FSCI_DEFINES_SVH
`define FSCI_CLK_HZ      20000000
`define FSCI_BAUD        4800
`define FSCI_BAUD_DIV    (`FSCI_CLK_HZ / `FSCI_BAUD)
`define FSCI_FIFO_DEPTH  8
`define FSCI_ASC_CR      8'h0d
`define FSCI_ASC_LF      8'h0a
`define FSCI_ASC_SP      8'h20
`define FSCI_ASC_QM      8'h3f
`define FSCI_ASC_0       8'h30
`define FSCI_ASC_9       8'h39
`define FSCI_ASC_A       8'h41
`define FSCI_ASC_F       8'h46
`define FSCI_ASC_Z       8'h5a
`define FSCI_ASC_HEXOFS  8'h37
`define FSCI_CMD_C       8'h43
`define FSCI_CMD_D       8'h44
`define FSCI_CMD_E       8'h45
`define FSCI_CMD_H       8'h48
`define FSCI_CMD_L       8'h4c
`define FSCI_CMD_M       8'h4d
`define FSCI_CMD_N       8'h4e
`define FSCI_CMD_O       8'h4f
`define FSCI_CMD_P       8'h50
`define FSCI_CMD_R       8'h52
`define FSCI_CMD_S       8'h53
`define FSCI_CMD_T       8'h54
`define FSCI_CMD_V       8'h56
`define FSCI_CMD_W       8'h57
`define FSCI_CMD_X       8'h58
`define FSCI_MODE_ONE    8'h01
`define FSCI_MODE_TWO    8'h02
`define FSCI_TUNE_MAX    16'h03ff
`define FSCI_DEF_AVG     16'h0128
`define FSCI_DEF_CF      8'h08
`define FSCI_DEF_LOCK    8'h04
`define FSCI_DEF_HOLD    8'h08
`define FSCI_DEF_WAIT    8'hc8
`define FSCI_DEF_NEG     8'h03
`define FSCI_DEF_OUT     8'h02
`define FSCI_DEF_SLOPE   8'h01
`define FSCI_DEF_AVGM    8'h01
`define FSCI_VERSION     8'h01
`define FSCI_PSTR_LAST   6'd48
`define FSCI_MENU_LAST   6'd19
`define FSCI_VER_LAST    6'd7
`endif

/* File: shared/fsci_pkg.sv */
// Purpose: types shared by the serial command interpreter
// Assumes: nothing beyond the defines header
// Notes:   parameter set travels as one packed struct
package fsci_pkg;
	typedef struct packed {
		logic [15:0] avg_cycle;
		logic [7:0]  cf_thresh;
		logic [7:0]  lock_limit;
		logic [7:0]  hold_limit;
		logic [7:0]  hold_wait;
		logic [7:0]  negate_thr;
		logic [7:0]  out_mode;
		logic [7:0]  tune_slope;
		logic [7:0]  avg_mode;
	} fsci_params_t;
	typedef enum logic [1:0] {MSG_NONE, MSG_MENU, MSG_PARAM, MSG_VER} fsci_msg_t;
	typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP}
		fsci_ser_t;
endpackage

/* File: rtl/fsci_top.sv */
// Purpose: serial command interpreter for the frequency locked loop
// Assumes: 20 MHz core_clk, async active-low resetn, 8N1 serial link
// Notes:   text replies pass through an 8-word fifo to the transmitter
`include "fsci_defines.svh"

// ==========================================================
// fifo
module fsci_fifo #(
	parameter int W = 8,
	parameter int D = `FSCI_FIFO_DEPTH
) (
	input  wire logic         core_clk,  // system clock
	input  wire logic         resetn,    // async reset, active low
	input  wire logic         clr,       // soft clear
	input  wire logic [W-1:0] in_data,   // write data
	input  wire logic         in_valid,  // write request
	output logic              in_ready,  // room available
	output logic [W-1:0]      out_data,  // read data
	output logic              out_valid, // data available
	input  wire logic         out_ready  // reader takes word
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	// handshake terms, full and empty from the count
	assign in_ready  = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_r];

	// storage write
	always_ff @(posedge core_clk) begin
		if (push)
			mem[wr_r] <= in_data;
	end

	// pointers and count
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else if (clr) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wr_r <= (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
			if (pop)
				rd_r <= (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // fsci_fifo

// ==========================================================
// top
module fsci_top #(
	parameter int BAUD_DIV = `FSCI_BAUD_DIV
) (
	input  wire logic         core_clk,        // 20 MHz system clock
	input  wire logic         resetn,          // async reset, active low
	input  wire logic         rx_pin,          // serial data in
	output logic              tx_pin,          // serial data out
	input  wire logic         pulse_per_second_input, // 1 Hz reference
	input  wire logic         loop_locked,     // loop in locked state
	input  wire logic [13:0]  loop_dac,        // loop tuning word
	output fsci_pkg::fsci_params_t params,     // loop parameters
	output logic              loop_enabled,    // closed loop active
	output logic              alarm_clear,     // pulse, clear alarms
	output logic              sample_clear,    // pulse, clear counter
	output logic              soft_reset,      // pulse, restart all but serial and pps logic
	output logic              pps_rise,        // pulse, reference edge
	output logic              ref_enable,      // reference output enable
	output logic [13:0]       tune_code        // oscillator tuning word
);
	localparam int HALF = BAUD_DIV / 2;

	// ==========================================================
	// functions
	function automatic logic [7:0] hex_asc(input logic [3:0] n);
		hex_asc = (n > 4'h9) ? 8'(n) + `FSCI_ASC_HEXOFS : 8'(n) + `FSCI_ASC_0;
	endfunction

	function automatic logic [8:0] msg_char(input fsci_pkg::fsci_msg_t m,
		input logic [5:0] i, input fsci_pkg::fsci_params_t p);
		logic [159:0] menu;
		logic [63:0]  ver, fld;
		logic [7:0]   lt, v;
		logic [5:0]   k, q;
		menu = {`FSCI_ASC_QM, "ACDEFHLMNOPRSTVWX", `FSCI_ASC_CR, `FSCI_ASC_LF};
		ver  = {"VER ", hex_asc(4'(`FSCI_VERSION >> 4)),
			hex_asc(4'(`FSCI_VERSION)), `FSCI_ASC_CR, `FSCI_ASC_LF};
		fld  = {p.cf_thresh, p.lock_limit, p.hold_limit, p.hold_wait,
			p.negate_thr, p.out_mode, p.tune_slope, p.avg_mode};
		k = (i - 6'd7) / 6'd5;
		q = (i - 6'd7) % 6'd5;
		lt = 8'("FLHWNOXM" >> (8'd8 * (8'd7 - 8'(k))));
		v  = fld[63 - 8*k -: 8];
		msg_char = '0;
		case (m)
			fsci_pkg::MSG_MENU:
				msg_char = {i == `FSCI_MENU_LAST, menu[159 - 8*i -: 8]};
			fsci_pkg::MSG_VER:
				msg_char = {i == `FSCI_VER_LAST, ver[63 - 8*i -: 8]};
			fsci_pkg::MSG_PARAM: begin
				if (i == 6'd0)
					msg_char = {1'b0, `FSCI_CMD_S};
				else if (i < 6'd2 || i == 6'd6)
					msg_char = {1'b0, `FSCI_ASC_SP};
				else if (i < 6'd6)
					msg_char = {1'b0, hex_asc(p.avg_cycle[15 - 4*(i-2) -: 4])};
				else if (i == `FSCI_PSTR_LAST - 6'd1)
					msg_char = {1'b0, `FSCI_ASC_CR};
				else if (i == `FSCI_PSTR_LAST)
					msg_char = {1'b1, `FSCI_ASC_LF};
				else if (q == 6'd0)
					msg_char = {1'b0, lt};
				else if (q == 6'd2)
					msg_char = {1'b0, hex_asc(v[7:4])};
				else if (q == 6'd3)
					msg_char = {1'b0, hex_asc(v[3:0])};
				else
					msg_char = {1'b0, `FSCI_ASC_SP};
			end
			default: msg_char = {1'b1, `FSCI_ASC_LF};
		endcase
	endfunction

	// ==========================================================
	// declarations
	logic [2:0]  rx_sync_r, pps_sync_r, rx_bit_r, tx_bit_r;
	logic [2:0]  ndig_r, ex_ndig_r;
	logic [15:0] rx_cnt_r, arg_r, tx_cnt_r;
	logic [7:0]  rx_sh_r, cmd_r, f_data, tx_sh_r;
	logic        rx_done_r, have_r, cr_r, bad_r, go_r, srst_r, is_hex;
	logic        ok0, ok8, ok12, ok16, en_r, f_ready, f_valid, f_take;
	logic [3:0]  nib;
	logic [9:0]  man_r;
	logic [5:0]  idx_r;
	logic [8:0]  ch;
	fsci_pkg::fsci_ser_t    rx_st_r, tx_st_r;
	fsci_pkg::fsci_params_t prm_r;
	fsci_pkg::fsci_msg_t    msg_r;

	// ==========================================================
	// receiver, 8N1 sampled mid-bit after three-flop sync
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			rx_sync_r <= 3'h7;
		else
			rx_sync_r <= {rx_sync_r[1:0], rx_pin};
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rx_st_r   <= fsci_pkg::SER_IDLE;
			rx_cnt_r  <= '0;
			rx_bit_r  <= '0;
			rx_sh_r   <= '0;
			rx_done_r <= 1'b0;
		end else begin
			rx_done_r <= 1'b0;
			rx_cnt_r  <= rx_cnt_r + 16'h0001;
			case (rx_st_r) // RQ19
				fsci_pkg::SER_IDLE: begin
					rx_cnt_r <= '0;
					if (!rx_sync_r[2])
						rx_st_r <= fsci_pkg::SER_START;
				end
				fsci_pkg::SER_START:
					if (rx_cnt_r == 16'(HALF)) begin
						rx_cnt_r <= '0;
						rx_bit_r <= '0;
						rx_st_r  <= rx_sync_r[2] ? fsci_pkg::SER_IDLE
							: fsci_pkg::SER_DATA;
					end
				fsci_pkg::SER_DATA:
					if (rx_cnt_r == 16'(BAUD_DIV - 1)) begin
						rx_cnt_r <= '0;
						rx_sh_r  <= {rx_sync_r[2], rx_sh_r[7:1]};
						rx_bit_r <= rx_bit_r + 3'h1;
						if (rx_bit_r == 3'h7)
							rx_st_r <= fsci_pkg::SER_STOP;
					end
				fsci_pkg::SER_STOP:
					if (rx_cnt_r == 16'(BAUD_DIV - 1)) begin
						rx_done_r <= rx_sync_r[2];
						rx_st_r   <= fsci_pkg::SER_IDLE;
					end
				default: rx_st_r <= fsci_pkg::SER_IDLE;
			endcase
		end
	end

	// ==========================================================
	// line assembly: letter, hex digits, then cr lf
	assign is_hex = (rx_sh_r >= `FSCI_ASC_0 && rx_sh_r <= `FSCI_ASC_9) ||
		(rx_sh_r >= `FSCI_ASC_A && rx_sh_r <= `FSCI_ASC_F);
	assign nib = (rx_sh_r > `FSCI_ASC_9) ? 4'(rx_sh_r - `FSCI_ASC_HEXOFS)
		: 4'(rx_sh_r - `FSCI_ASC_0);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cmd_r     <= '0;
			arg_r     <= '0;
			ndig_r    <= '0;
			ex_ndig_r <= '0;
			have_r    <= 1'b0;
			cr_r      <= 1'b0;
			bad_r     <= 1'b0;
			go_r      <= 1'b0;
		end else if (srst_r) begin
			have_r <= 1'b0;
			cr_r   <= 1'b0;
			bad_r  <= 1'b0;
			ndig_r <= '0;
			go_r   <= 1'b0;
		end else begin
			go_r <= 1'b0;
			if (rx_done_r) begin
				if (rx_sh_r == `FSCI_ASC_CR)
					cr_r <= 1'b1;
				else if (rx_sh_r == `FSCI_ASC_LF) begin
					go_r      <= cr_r & have_r & ~bad_r; // RQ23
					ex_ndig_r <= ndig_r;
					have_r    <= 1'b0;
					cr_r      <= 1'b0;
					bad_r     <= 1'b0;
					ndig_r    <= '0;
				end else if (!have_r) begin
					cmd_r  <= rx_sh_r;
					arg_r  <= '0;
					have_r <= 1'b1;
					bad_r  <= cr_r | ~((rx_sh_r >= `FSCI_ASC_A && // RQ22
						rx_sh_r <= `FSCI_ASC_Z) || rx_sh_r == `FSCI_ASC_QM);
				end else if (is_hex && ndig_r != 3'h4 && !cr_r) begin
					arg_r  <= {arg_r[11:0], nib};
					ndig_r <= ndig_r + 3'h1;
				end else
					bad_r <= 1'b1; // RQ22
			end
		end
	end

	// ==========================================================
	// argument checks
	assign ok0  = go_r && ex_ndig_r == 3'h0;
	assign ok16 = go_r && ex_ndig_r == 3'h4 && arg_r != 16'h0000; // RQ25
	assign ok8  = go_r && ex_ndig_r == 3'h2 && arg_r[7:0] != 8'h00; // RQ25
	assign ok12 = go_r && ex_ndig_r == 3'h2 && (arg_r[7:0] == `FSCI_MODE_ONE
		|| arg_r[7:0] == `FSCI_MODE_TWO); // RQ25

	// soft reset pulse, applied next cycle to line assembly, parameters, loop enable, replies and fifo
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			srst_r <= 1'b0;
		else
			srst_r <= ok0 && cmd_r == `FSCI_CMD_R; // RQ13
	end

	// parameter updates
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn || srst_r) begin // RQ13
			prm_r <= '{`FSCI_DEF_AVG, `FSCI_DEF_CF, `FSCI_DEF_LOCK,
				`FSCI_DEF_HOLD, `FSCI_DEF_WAIT, `FSCI_DEF_NEG, `FSCI_DEF_OUT,
				`FSCI_DEF_SLOPE, `FSCI_DEF_AVGM};
		end else begin
			if (ok8 && cmd_r == `FSCI_ASC_F)
				prm_r.cf_thresh <= arg_r[7:0]; // RQ6
			if (ok8 && cmd_r == `FSCI_CMD_H)
				prm_r.hold_limit <= arg_r[7:0]; // RQ7
			if (ok8 && cmd_r == `FSCI_CMD_L)
				prm_r.lock_limit <= arg_r[7:0]; // RQ8
			if (ok12 && cmd_r == `FSCI_CMD_M)
				prm_r.avg_mode <= arg_r[7:0]; // RQ9
			if (ok8 && cmd_r == `FSCI_CMD_N)
				prm_r.negate_thr <= arg_r[7:0]; // RQ10
			if (ok12 && cmd_r == `FSCI_CMD_O)
				prm_r.out_mode <= arg_r[7:0]; // RQ11
			if (ok16 && cmd_r == `FSCI_CMD_S)
				prm_r.avg_cycle <= arg_r; // RQ14
			if (ok8 && cmd_r == `FSCI_CMD_W)
				prm_r.hold_wait <= arg_r[7:0]; // RQ17
			if (ok12 && cmd_r == `FSCI_CMD_X)
				prm_r.tune_slope <= arg_r[7:0]; // RQ18
		end
	end

	// loop enable and manual coarse tune
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn || srst_r) begin
			en_r  <= 1'b1;
			man_r <= '0;
		end else if (go_r) begin
			if (ok0 && cmd_r == `FSCI_CMD_D)
				en_r <= 1'b0; // RQ4
			if (ok0 && cmd_r == `FSCI_CMD_E)
				en_r <= 1'b1; // RQ5
			if (ex_ndig_r == 3'h4 && cmd_r == `FSCI_CMD_T && !en_r &&
				arg_r <= `FSCI_TUNE_MAX)
				man_r <= arg_r[9:0]; // RQ15
		end
	end

	// command pulses
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			alarm_clear  <= 1'b0;
			sample_clear <= 1'b0;
		end else begin
			alarm_clear  <= ok0 && cmd_r == `FSCI_ASC_A; // RQ2
			sample_clear <= ok0 && cmd_r == `FSCI_CMD_C; // RQ3
		end
	end

	// ==========================================================
	// reply generator, stalls on a full fifo
	assign ch = msg_char(msg_r, idx_r, prm_r);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn || srst_r) begin
			msg_r <= fsci_pkg::MSG_NONE;
			idx_r <= '0;
		end else if (msg_r != fsci_pkg::MSG_NONE) begin
			if (f_ready) begin
				idx_r <= idx_r + 6'd1;
				if (ch[8]) begin
					msg_r <= fsci_pkg::MSG_NONE;
					idx_r <= '0;
				end
			end
		end else if (go_r) begin
			if (ok0 && cmd_r == `FSCI_ASC_QM)
				msg_r <= fsci_pkg::MSG_MENU; // RQ1
			else if (ok0 && cmd_r == `FSCI_CMD_V)
				msg_r <= fsci_pkg::MSG_VER; // RQ16
			else if ((ok0 && cmd_r == `FSCI_CMD_P) || // RQ12
				(ok8 && (cmd_r == `FSCI_ASC_F || cmd_r == `FSCI_CMD_H ||
				cmd_r == `FSCI_CMD_L || cmd_r == `FSCI_CMD_N ||
				cmd_r == `FSCI_CMD_W)) ||
				(ok12 && cmd_r == `FSCI_CMD_M) ||
				(ok16 && cmd_r == `FSCI_CMD_S))
				msg_r <= fsci_pkg::MSG_PARAM; // RQ6 RQ14
		end
	end

	fsci_fifo #(.W(8), .D(`FSCI_FIFO_DEPTH)) u_fifo (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.clr       (srst_r),
		.in_data   (ch[7:0]),
		.in_valid  (msg_r != fsci_pkg::MSG_NONE),
		.in_ready  (f_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (f_take)
	);

	// ==========================================================
	// transmitter, 8N1
	assign f_take = f_valid && tx_st_r == fsci_pkg::SER_IDLE;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tx_st_r  <= fsci_pkg::SER_IDLE;
			tx_cnt_r <= '0;
			tx_bit_r <= '0;
			tx_sh_r  <= '0;
			tx_pin   <= 1'b1;
		end else begin
			tx_cnt_r <= tx_cnt_r + 16'h0001;
			case (tx_st_r) // RQ19
				fsci_pkg::SER_IDLE: begin
					tx_cnt_r <= '0;
					tx_pin   <= 1'b1;
					if (f_take) begin
						tx_sh_r <= f_data;
						tx_pin  <= 1'b0;
						tx_st_r <= fsci_pkg::SER_START;
					end
				end
				fsci_pkg::SER_START:
					if (tx_cnt_r == 16'(BAUD_DIV - 1)) begin
						tx_cnt_r <= '0;
						tx_bit_r <= '0;
						tx_pin   <= tx_sh_r[0];
						tx_st_r  <= fsci_pkg::SER_DATA;
					end
				fsci_pkg::SER_DATA:
					if (tx_cnt_r == 16'(BAUD_DIV - 1)) begin
						tx_cnt_r <= '0;
						tx_bit_r <= tx_bit_r + 3'h1;
						tx_sh_r  <= {1'b1, tx_sh_r[7:1]};
						tx_pin   <= (tx_bit_r == 3'h7) ? 1'b1 : tx_sh_r[1];
						if (tx_bit_r == 3'h7)
							tx_st_r <= fsci_pkg::SER_STOP;
					end
				fsci_pkg::SER_STOP:
					if (tx_cnt_r == 16'(BAUD_DIV - 1))
						tx_st_r <= fsci_pkg::SER_IDLE;
				default: tx_st_r <= fsci_pkg::SER_IDLE;
			endcase
		end
	end

	// ==========================================================
	// reference edge, reference enable, tuning word
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pps_sync_r <= '0;
			pps_rise   <= 1'b0;
		end else begin
			pps_sync_r <= {pps_sync_r[1:0], pulse_per_second_input};
			pps_rise   <= pps_sync_r[1] & ~pps_sync_r[2]; // RQ20
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ref_enable <= 1'b1;
			tune_code  <= '0;
		end else begin
			ref_enable <= (prm_r.out_mode == `FSCI_MODE_ONE) | loop_locked; // RQ11
			if (prm_r.tune_slope == `FSCI_MODE_TWO) // RQ21
				tune_code <= ~(en_r ? loop_dac : {man_r, 4'h0});
			else
				tune_code <= en_r ? loop_dac : {man_r, 4'h0}; // RQ15
		end
	end

	// registered outputs
	assign params       = prm_r;
	assign loop_enabled = en_r;
	assign soft_reset   = srst_r;
endmodule // fsci_top

/* File: testbench/fsci_monitor.sv */
// Purpose: port checks for the serial command interpreter
// Assumes: one core_clk domain, resetn async active low
// Notes:   bound to fsci_top below the module
`include "fsci_defines.svh"

// ========
// checker
module fsci_monitor #(
	parameter int BAUD_DIV = 16
) (
	input wire logic                   core_clk,     // clock
	input wire logic                   resetn,       // reset
	input wire logic                   rx_pin,       // serial in
	input wire logic                   tx_pin,       // serial out
	input wire logic                   pulse_per_second_input, // ref
	input wire logic                   loop_locked,  // lock
	input wire logic [13:0]            loop_dac,     // loop word
	input wire fsci_pkg::fsci_params_t params,       // parameters
	input wire logic                   loop_enabled, // closed loop
	input wire logic                   alarm_clear,  // pulse
	input wire logic                   sample_clear, // pulse
	input wire logic                   soft_reset,   // pulse
	input wire logic                   pps_rise,     // pulse
	input wire logic                   ref_enable,   // ref on
	input wire logic [13:0]            tune_code     // tune word
);
	localparam fsci_pkg::fsci_params_t DEF = {`FSCI_DEF_AVG,
		`FSCI_DEF_CF, `FSCI_DEF_LOCK, `FSCI_DEF_HOLD, `FSCI_DEF_WAIT,
		`FSCI_DEF_NEG, `FSCI_DEF_OUT, `FSCI_DEF_SLOPE, `FSCI_DEF_AVGM};
	logic [15:0] lo_cnt_r; // length of the low run on tx_pin

	// a low run on the line must be whole bit times
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			lo_cnt_r <= 16'h0000;
		else
			lo_cnt_r <= tx_pin ? 16'h0000 : lo_cnt_r + 16'h0001;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// ========
	// assertions
	a_alarm_one_pulse: assert property (alarm_clear |=> !alarm_clear)
		else $error("alarm clear pulse too long");
	a_sample_one_pulse: assert property (
		sample_clear |=> !sample_clear)
		else $error("sample clear pulse too long");
	a_soft_reset_dflt: assert property (
		soft_reset |=> params == DEF && loop_enabled)
		else $error("soft reset left non-default state");
	a_ref_follows_lock: assert property (
		params.out_mode == 8'h02 |=> ref_enable == $past(loop_locked))
		else $error("reference enable not following lock");
	a_ref_always_on: assert property (
		params.out_mode == 8'h01 |=> ref_enable)
		else $error("reference enable low in mode one");
	a_tune_follows_loop: assert property (
		loop_enabled |=> tune_code == ($past(params.tune_slope) == 8'h02 ?
			~$past(loop_dac) : $past(loop_dac)))
		else $error("tuning word not following loop");
	a_manual_coarse_only: assert property (
		!loop_enabled |=> tune_code[3:0] ==
			($past(params.tune_slope) == 8'h02 ? 4'hf : 4'h0))
		else $error("fine bits set in manual state");
	a_pps_edge_pulse: assert property (
		$rose(pulse_per_second_input) |-> ##[1:5] pps_rise ##1 !pps_rise)
		else $error("reference edge pulse missing");
	a_tx_whole_bits: assert property (
		$rose(tx_pin) |-> lo_cnt_r != 0 && lo_cnt_r % BAUD_DIV == 0)
		else $error("serial low run not whole bits");

	cover property (soft_reset);
	cover property (!loop_enabled ##1 loop_enabled);
	cover property ($rose(tx_pin));
endmodule // fsci_monitor

bind fsci_top fsci_monitor #(.BAUD_DIV(BAUD_DIV)) u_mon (
	.core_clk(core_clk), .resetn(resetn), .rx_pin(rx_pin),
	.tx_pin(tx_pin), .pulse_per_second_input(pulse_per_second_input),
	.loop_locked(loop_locked), .loop_dac(loop_dac), .params(params),
	.loop_enabled(loop_enabled), .alarm_clear(alarm_clear),
	.sample_clear(sample_clear), .soft_reset(soft_reset),
	.pps_rise(pps_rise), .ref_enable(ref_enable), .tune_code(tune_code));

/* File: testbench/fsci_term.sv */
// Purpose: terminal model sending command lines, collecting replies
// Assumes: 8N1 framing, BIT core_clk cycles per bit
// Notes:   lines go out exactly as given, then CR and LF
`include "fsci_defines.svh"

// ========
// terminal
module fsci_term #(
	parameter int BIT = 10
) (
	input wire logic core_clk, // system clock
	input wire logic rx_line,  // replies in
	output logic     tx_line   // commands out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rxq[$]; // received bytes
	logic [7:0] b;      // byte being received

	initial tx_line = 1'b1;

	// one frame: start, eight bits lsb first, stop
	task automatic send_byte(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		@(posedge core_clk);
		#1;
		for (int i = 0; i < 10; i++) begin
			tx_line = f[i];
			repeat (BIT) @(posedge core_clk);
			#1;
		end
	endtask

	// case of letters is left as the caller wrote it
	task automatic send_line(input string s);
		foreach (s[i]) send_byte(s[i]);
		send_byte(`FSCI_ASC_CR);
		send_byte(`FSCI_ASC_LF);
	endtask

	// sample replies mid-bit, keep only bytes with a good stop bit
	always begin
		@(negedge rx_line);
		repeat (BIT / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge core_clk);
			b[i] = rx_line;
		end
		repeat (BIT) @(posedge core_clk);
		if (rx_line === 1'b1) rxq.push_back(b);
	end
endmodule // fsci_term

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the serial command interpreter
// Assumes: bit time cut to BIT core_clk cycles
// Notes:   table rows first, then hand-written cases
`include "fsci_defines.svh"

// ========
// bench
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT = 10;
	typedef struct {
		string       cmd; // line sent
		int          lo;  // lsb of changed field, -1 none
		logic [15:0] v;   // new field value
		bit          ps;  // parameter string expected
		string       rep; // other reply, CR as m and LF as j
	} fsci_row_t;
	typedef fsci_pkg::fsci_params_t fsci_prm_t;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        pps_in = 1'b0;
	logic        loop_locked = 1'b0;
	logic [13:0] loop_dac = 14'h0000;
	wire logic   rx_pin;
	logic        tx_pin, loop_enabled, alarm_clear;
	logic        sample_clear, soft_reset, pps_rise;
	logic        ref_enable;
	logic [13:0] tune_code;
	fsci_prm_t   params, ep, dflt;
	int          bad_count, samples_checked;
	int          n_alarm, n_samp, n_rst, n_pps;
	string       es;
	fsci_row_t rows[] = '{
		'{"?", -1, 16'h0000, 1'b0, "?ACDEFHLMNOPRSTVWXmj"},
		'{"V", -1, 16'h0000, 1'b0, "VER 01mj"},
		'{"P", -1, 16'h0000, 1'b1, ""},
		'{"F01", 56, 16'h0001, 1'b1, ""},
		'{"HFF", 40, 16'h00ff, 1'b1, ""},
		'{"L7E", 48, 16'h007e, 1'b1, ""},
		'{"M02", 0, 16'h0002, 1'b1, ""},
		'{"M01", 0, 16'h0001, 1'b1, ""},
		'{"N5A", 24, 16'h005a, 1'b1, ""},
		'{"SFFFF", 64, 16'hffff, 1'b1, ""},
		'{"W01", 32, 16'h0001, 1'b1, ""},
		'{"O02", 16, 16'h0002, 1'b0, ""},
		'{"O01", 16, 16'h0001, 1'b0, ""},
		'{"X02", 8, 16'h0002, 1'b0, ""},
		'{"M03", -1, 16'h0000, 1'b0, ""},
		'{"F00", -1, 16'h0000, 1'b0, ""},
		'{"S0000", -1, 16'h0000, 1'b0, ""},
		'{"h10", -1, 16'h0000, 1'b0, ""},
		'{"Q", -1, 16'h0000, 1'b0, ""}};

	always #25 core_clk = ~core_clk;

	fsci_top #(.BAUD_DIV(BIT)) dut (
		.core_clk(core_clk), .resetn(resetn), .rx_pin(rx_pin),
		.tx_pin(tx_pin), .pulse_per_second_input(pps_in),
		.loop_locked(loop_locked), .loop_dac(loop_dac), .params(params),
		.loop_enabled(loop_enabled), .alarm_clear(alarm_clear),
		.sample_clear(sample_clear), .soft_reset(soft_reset),
		.pps_rise(pps_rise), .ref_enable(ref_enable),
		.tune_code(tune_code));
	fsci_term #(.BIT(BIT)) term (.core_clk(core_clk), .rx_line(tx_pin),
		.tx_line(rx_pin));

	// count the one-cycle pulses
	always @(posedge core_clk) begin
		if (alarm_clear === 1'b1) n_alarm++;
		if (sample_clear === 1'b1) n_samp++;
		if (soft_reset === 1'b1) n_rst++;
		if (pps_rise === 1'b1) n_pps++;
	end

	// ========
	// tasks
	task automatic chk_v(input string nm, input logic [79:0] e, g);
		samples_checked++;
		if (e !== g) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_s(input string nm, e, g);
		samples_checked++;
		if (e != g) begin
			bad_count++;
			$display("[ERR] %s expected %s seen %s", nm, e, g);
		end
	endtask

	function automatic string pstr(input fsci_pkg::fsci_params_t p);
		string s;
		s = $sformatf("S %h F %h L %h H %h W %h N %h O %h X %h M %h",
			p.avg_cycle, p.cf_thresh, p.lock_limit, p.hold_limit,
			p.hold_wait, p.negate_thr, p.out_mode, p.tune_slope, p.avg_mode);
		return {s.toupper(), " mj"};
	endfunction

	// send a line, collect its reply, control bytes shown lower case
	task automatic run(input string c, e);
		string s;
		int k;
		s = "";
		k = 0;
		term.rxq.delete();
		term.send_line(c);
		while (term.rxq.size() < e.len() && k < 12 * BIT * 50) begin
			@(posedge core_clk);
			k++;
		end
		repeat (20 * BIT) @(posedge core_clk);
		#1;
		foreach (term.rxq[j])
			s = {s, string'(term.rxq[j] < 8'h20 ? term.rxq[j] + 8'h60 :
				term.rxq[j])};
		chk_s(c, e, s);
	endtask

	task automatic conclude();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// cut a hang short
	initial begin
		repeat (95000) @(posedge core_clk);
		bad_count++;
		conclude();
	end

	// ========
	// main sequence
	initial begin
		dflt = {`FSCI_DEF_AVG, `FSCI_DEF_CF, `FSCI_DEF_LOCK, `FSCI_DEF_HOLD,
			`FSCI_DEF_WAIT, `FSCI_DEF_NEG, `FSCI_DEF_OUT, `FSCI_DEF_SLOPE,
			`FSCI_DEF_AVGM};
		ep = dflt;
		repeat (6) @(posedge core_clk);
		#1 resetn = 1'b1;
		foreach (rows[i]) begin
			if (rows[i].lo == 64) ep.avg_cycle = rows[i].v;
			else if (rows[i].lo >= 0) ep[rows[i].lo +: 8] = rows[i].v[7:0];
			es = rows[i].ps ? pstr(ep) : rows[i].rep;
			run(rows[i].cmd, es);
			chk_v("params", ep, params);
		end
		loop_dac = 14'h1234;
		run("T0155", "");
		chk_v("tune", 80'(14'h2dcb), 80'(tune_code));
		run("D", "");
		chk_v("enabled", 80'(1'b0), 80'(loop_enabled));
		run("T03FF", "");
		chk_v("tune", 80'(14'h000f), 80'(tune_code));
		run("T0400", "");
		chk_v("tune", 80'(14'h000f), 80'(tune_code));
		run("E", "");
		chk_v("enabled", 80'(1'b1), 80'(loop_enabled));
		run("A", "");
		run("C", "");
		chk_v("alarm", 80'(1), 80'(n_alarm));
		chk_v("samples", 80'(1), 80'(n_samp));
		chk_v("ref", 80'(1'b1), 80'(ref_enable));
		pps_in = 1'b1;
		repeat (10) @(posedge core_clk);
		#1 pps_in = 1'b0;
		repeat (10) @(posedge core_clk);
		#1 chk_v("pps", 80'(1), 80'(n_pps));
		run("R", "");
		chk_v("params", dflt, params);
		chk_v("soft", 80'({n_rst[1:0], loop_enabled}), 80'(3'b011));
		chk_v("ref", 80'(1'b0), 80'(ref_enable));
		loop_locked = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 chk_v("ref", 80'(1'b1), 80'(ref_enable));
		run("X02", "");
		resetn = 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk_v("params", dflt, params);
		chk_v("tx idle", 80'(1'b1), 80'(tx_pin));
		conclude();
	end
endmodule // tb_top
